// ==== src/osr_params.svh ====
// constants of the output signal router: register offsets, reset values, field widths and codes
// assumes inclusion by the package, the modules of this block and the bench
`ifndef OSR_PARAMS_SVH
`define OSR_PARAMS_SVH

`define OSR_ADDR_W          8
`define OSR_OFF_SEL_A       8'h00
`define OSR_OFF_SEL_B       8'h04
`define OSR_OFF_SEL_NEAR    8'h08
`define OSR_OFF_POL_INV     8'h0C
`define OSR_OFF_ORIGIN      8'h10
`define OSR_OFF_STATUS      8'h14

`define OSR_RST_SEL_A       16'h0000
`define OSR_RST_SEL_B       16'h0100
`define OSR_RST_SEL_NEAR    16'h0000
`define OSR_RST_POL_INV     16'h0000
`define OSR_RST_ORIGIN      32'h0000_0000

`define OSR_SEL_W           4
`define OSR_NUM_SIG         9
`define OSR_NUM_OUT         3

`define OSR_CODE_NONE       4'h0
`define OSR_CODE_OUT1       4'h1
`define OSR_CODE_OUT3       4'h3

`define OSR_QUAD_DIV        16
`define OSR_EDM_MAX_MS      20
`define OSR_CLK_KHZ         50000

`endif

// ==== src/osr_pkg.sv ====
// types shared by the output signal router modules
// assumes osr_params.svh is on the include path
`include "osr_params.svh"

package osr_pkg;

    typedef enum logic [1:0]
    {
        OSR_MODE_POSITION,
        OSR_MODE_SPEED,
        OSR_MODE_FORCE
    } osr_mode_t;

    // index of each routable status signal in the routing vector
    typedef enum int
    {
        OSR_SIG_POS_DONE,
        OSR_SIG_SPEED_MATCH,
        OSR_SIG_MOVING,
        OSR_SIG_READY,
        OSR_SIG_FORCE_LIM,
        OSR_SIG_SPEED_LIM,
        OSR_SIG_BRAKE,
        OSR_SIG_WARN,
        OSR_SIG_NEAR
    } osr_sig_t;

    typedef logic [`OSR_SEL_W-1:0] osr_code_t;

endpackage : osr_pkg

// ==== src/osr_quad_gen.sv ====
// quadrature and origin pulse generator driven by decoded scale position words
// assumes position words arrive synchronous to clk, one per pos_vld_i pulse
`timescale 1ns/1ps
`include "osr_params.svh"

module osr_quad_gen
    import osr_pkg::*;
#(
    parameter int POS_W = 32,
    parameter int DIV   = `OSR_QUAD_DIV
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [POS_W-1:0] pos_i,
    input  wire logic             pos_vld_i,
    input  wire logic [POS_W-1:0] origin_i,
    output logic                  a_o,
    output logic                  b_o,
    output logic                  c_o
);

    logic [POS_W-1:0] cur_r;
    logic [POS_W-1:0] cur_nxt;
    logic [POS_W-1:0] tgt_r;
    logic [1:0]       ph_r;
    logic [1:0]       ph_nxt;
    logic [15:0]      div_r;

    // one step of the counter per enable, so the pulse rate is bounded
    wire step_en = (div_r == 16'(DIV - 1));
    wire go_up   = step_en && (tgt_r > cur_r);
    wire go_dn   = step_en && (tgt_r < cur_r);

    // gray sequence 00-01-11-10 forward, reverse backward
    assign ph_nxt  = go_up ? {ph_r[0], ~ph_r[1]} : go_dn ? {~ph_r[0], ph_r[1]} : ph_r;
    assign cur_nxt = go_up ? cur_r + POS_W'(1) : go_dn ? cur_r - POS_W'(1) : cur_r;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            cur_r <= '0;
            tgt_r <= '0;
            ph_r  <= 2'h0;
            div_r <= 16'h0000;
            a_o   <= 1'b0;
            b_o   <= 1'b0;
            c_o   <= 1'b0;
        end
        else
        begin
            div_r <= step_en ? 16'h0000 : div_r + 16'h0001;
            if (pos_vld_i)
                tgt_r <= pos_i;
            cur_r <= cur_nxt;
            ph_r  <= ph_nxt;
            a_o   <= ph_nxt[1];
            b_o   <= ph_nxt[0];
            c_o   <= (cur_nxt == origin_i);
        end
    end

endmodule : osr_quad_gen

// ==== src/osr_top.sv ====
// output signal router: routes status signals to three output circuits, drives the
// safety monitor output and the quadrature/origin pulse outputs; APB register access
// assumes all inputs synchronous to CORE_CLK_I; one clock, synchronous active-low reset
`timescale 1ns/1ps
`include "osr_params.svh"

module osr_top
    import osr_pkg::*;
#(
    parameter int POS_W  = 32,
    parameter int QDIV   = `OSR_QUAD_DIV
)
(
    input  wire logic             CORE_CLK_I,
    input  wire logic             RST_N_I,
    // apb slave
    input  wire logic             PSEL_I,
    input  wire logic             PENABLE_I,
    input  wire logic             PWRITE_I,
    input  wire logic [31:0]      PADDR_I,
    input  wire logic [31:0]      PWDATA_I,
    output logic [31:0]           PRDATA_O,
    output logic                  PREADY_O,
    output logic                  PSLVERR_O,
    // control mode of the drive
    input  wire logic [1:0]       CTRL_MODE_I,
    // internal status signals, high when the condition holds
    input  wire logic             POSITION_DONE_I,
    input  wire logic             SPEED_MATCH_I,
    input  wire logic             MOVING_I,
    input  wire logic             SERVO_READY_I,
    input  wire logic             FORCE_LIMITED_I,
    input  wire logic             SPEED_LIMITED_I,
    input  wire logic             HOLDING_BRAKE_I,
    input  wire logic             WARNING_I,
    input  wire logic             NEAR_I,
    // redundant safety base-block inputs, low when base block is demanded
    input  wire logic             SAFE_BLOCK_IN_1_N_I,
    input  wire logic             SAFE_BLOCK_IN_2_N_I,
    // decoded scale position words
    input  wire logic [POS_W-1:0] SCALE_POS_I,
    input  wire logic             SCALE_POS_VLD_I,
    // output circuits, high when the circuit is on
    output logic                  OUT_CIRCUIT_1_O,
    output logic                  OUT_CIRCUIT_2_O,
    output logic                  OUT_CIRCUIT_3_O,
    output logic                  SAFETY_MONITOR_OUT_O,
    output logic                  QUAD_PHASE_A_O,
    output logic                  QUAD_PHASE_A_N_O,
    output logic                  QUAD_PHASE_B_O,
    output logic                  QUAD_PHASE_B_N_O,
    output logic                  ORIGIN_PULSE_O,
    output logic                  ORIGIN_PULSE_N_O
);

    // registers
    logic [15:0]           sel_a_r;
    logic [15:0]           sel_b_r;
    logic [15:0]           sel_near_r;
    logic [15:0]           pol_inv_r;
    logic [POS_W-1:0]      origin_r;

    // apb decode
    wire  [`OSR_ADDR_W-1:0] addr       = PADDR_I[`OSR_ADDR_W-1:0];
    wire                    hi_zero    = (PADDR_I[31:`OSR_ADDR_W] == '0);
    wire                    hit_sel_a  = hi_zero && (addr == `OSR_OFF_SEL_A);
    wire                    hit_sel_b  = hi_zero && (addr == `OSR_OFF_SEL_B);
    wire                    hit_near   = hi_zero && (addr == `OSR_OFF_SEL_NEAR);
    wire                    hit_pol    = hi_zero && (addr == `OSR_OFF_POL_INV);
    wire                    hit_origin = hi_zero && (addr == `OSR_OFF_ORIGIN);
    wire                    hit_status = hi_zero && (addr == `OSR_OFF_STATUS);
    wire                    hit_any    = hit_sel_a | hit_sel_b | hit_near | hit_pol | hit_origin | hit_status;

    // the access completes on the second access cycle, when pready is high
    wire                    acc_done   = PSEL_I && PENABLE_I && PREADY_O;
    wire                    acc_first  = PSEL_I && PENABLE_I && !PREADY_O;
    wire                    wr_en      = acc_done && PWRITE_I && hit_any && !hit_status;

    // one write strobe per register
    wire                    wr_sel_a   = wr_en && hit_sel_a;
    wire                    wr_sel_b   = wr_en && hit_sel_b;
    wire                    wr_near    = wr_en && hit_near;
    wire                    wr_pol     = wr_en && hit_pol;
    wire                    wr_origin  = wr_en && hit_origin;

    // status view of the output circuits, the safety monitor, the non-inverted pulse outputs and its two safety base-block inputs
    wire  [31:0]            status_word = {22'h000000, SAFE_BLOCK_IN_2_N_I, SAFE_BLOCK_IN_1_N_I,
                                           SAFETY_MONITOR_OUT_O, ORIGIN_PULSE_O, QUAD_PHASE_B_O,
                                           QUAD_PHASE_A_O, OUT_CIRCUIT_3_O, OUT_CIRCUIT_2_O,
                                           OUT_CIRCUIT_1_O, 1'b0};

    wire  [31:0]            rd_mux =
        hit_sel_a  ? {16'h0000, sel_a_r}                  :
        hit_sel_b  ? {16'h0000, sel_b_r}                  :
        hit_near   ? {16'h0000, sel_near_r}               :
        hit_pol    ? {16'h0000, pol_inv_r}                :
        hit_origin ? 32'(origin_r)                        :
        hit_status ? status_word                          :
                     32'h0000_0000;

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
        begin
            PREADY_O  <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end
        else
        begin
            PREADY_O  <= acc_first;
            PRDATA_O  <= (acc_first && !PWRITE_I) ? rd_mux : 32'h0000_0000;
            PSLVERR_O <= acc_first && (!hit_any || (PWRITE_I && hit_status));
        end
    end

    // each register holds its value until the completing edge of a write to it
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
            sel_a_r <= `OSR_RST_SEL_A;
        else if (wr_sel_a)
            sel_a_r <= PWDATA_I[15:0];
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
            sel_b_r <= `OSR_RST_SEL_B;
        else if (wr_sel_b)
            sel_b_r <= PWDATA_I[15:0];
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
            sel_near_r <= `OSR_RST_SEL_NEAR;
        else if (wr_near)
            sel_near_r <= PWDATA_I[15:0];
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
            pol_inv_r <= `OSR_RST_POL_INV;
        else if (wr_pol)
            pol_inv_r <= PWDATA_I[15:0];
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
            origin_r <= POS_W'(`OSR_RST_ORIGIN);
        else if (wr_origin)
            origin_r <= PWDATA_I[POS_W-1:0];
    end

    // routing
    osr_mode_t                mode;
    logic [`OSR_NUM_SIG-1:0]  sig_raw;
    logic [`OSR_NUM_SIG-1:0]  sig_ok;
    logic [`OSR_NUM_SIG-1:0]  sig_act;
    osr_code_t                code [`OSR_NUM_SIG];
    logic [`OSR_NUM_OUT-1:0]  or_out;
    logic [`OSR_NUM_OUT-1:0]  fin_out;

    assign mode = osr_mode_t'(CTRL_MODE_I);

    assign sig_raw[OSR_SIG_POS_DONE]    = POSITION_DONE_I;
    assign sig_raw[OSR_SIG_SPEED_MATCH] = SPEED_MATCH_I;
    assign sig_raw[OSR_SIG_MOVING]      = MOVING_I;
    assign sig_raw[OSR_SIG_READY]       = SERVO_READY_I;
    assign sig_raw[OSR_SIG_FORCE_LIM]   = FORCE_LIMITED_I;
    assign sig_raw[OSR_SIG_SPEED_LIM]   = SPEED_LIMITED_I;
    assign sig_raw[OSR_SIG_BRAKE]       = HOLDING_BRAKE_I;
    assign sig_raw[OSR_SIG_WARN]        = WARNING_I;
    assign sig_raw[OSR_SIG_NEAR]        = NEAR_I;

    // position done, speed match, speed limited and near only evaluated in one control mode
    assign sig_ok[OSR_SIG_POS_DONE]    = (mode == OSR_MODE_POSITION);
    assign sig_ok[OSR_SIG_SPEED_MATCH] = (mode == OSR_MODE_SPEED);
    assign sig_ok[OSR_SIG_MOVING]      = 1'b1;
    assign sig_ok[OSR_SIG_READY]       = 1'b1;
    assign sig_ok[OSR_SIG_FORCE_LIM]   = 1'b1;
    assign sig_ok[OSR_SIG_SPEED_LIM]   = (mode == OSR_MODE_FORCE);
    assign sig_ok[OSR_SIG_BRAKE]       = 1'b1;
    assign sig_ok[OSR_SIG_WARN]        = 1'b1;
    assign sig_ok[OSR_SIG_NEAR]        = (mode == OSR_MODE_POSITION);

    assign sig_act = sig_raw & sig_ok;

    // selection codes, one nibble per signal
    assign code[OSR_SIG_POS_DONE]    = sel_a_r[3:0];
    assign code[OSR_SIG_SPEED_MATCH] = sel_a_r[7:4];
    assign code[OSR_SIG_MOVING]      = sel_a_r[11:8];
    assign code[OSR_SIG_READY]       = sel_a_r[15:12];
    assign code[OSR_SIG_FORCE_LIM]   = sel_b_r[3:0];
    assign code[OSR_SIG_SPEED_LIM]   = sel_b_r[7:4];
    assign code[OSR_SIG_BRAKE]       = sel_b_r[11:8];
    assign code[OSR_SIG_WARN]        = sel_b_r[15:12];
    assign code[OSR_SIG_NEAR]        = sel_near_r[3:0];

    // one OR per output circuit, then its inversion bit
    genvar k;
    generate
        for (k = 0; k < `OSR_NUM_OUT; k++)
        begin : g_out
            logic [`OSR_NUM_SIG-1:0] hits;
            genvar s;
            for (s = 0; s < `OSR_NUM_SIG; s++)
            begin : g_sig
                // codes 0 and above 3 drive nothing
                assign hits[s] = sig_act[s] && (code[s] == osr_code_t'(k + 1));
            end
            assign or_out[k]  = |hits;
            assign fin_out[k] = or_out[k] ^ pol_inv_r[k];
        end
    endgenerate

    // safety monitor: both channels demanding base block means both work normally
    wire edm_nxt = !SAFE_BLOCK_IN_1_N_I && !SAFE_BLOCK_IN_2_N_I;

    // quadrature generator
    logic qa;
    logic qb;
    logic qc;

    osr_quad_gen #(
        .POS_W (POS_W),
        .DIV   (QDIV)
    ) u_quad (
        .clk_i     (CORE_CLK_I),
        .rst_n_i   (RST_N_I),
        .pos_i     (SCALE_POS_I),
        .pos_vld_i (SCALE_POS_VLD_I),
        .origin_i  (origin_r),
        .a_o       (qa),
        .b_o       (qb),
        .c_o       (qc)
    );

    // output circuits after the inversion
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
        begin
            OUT_CIRCUIT_1_O <= 1'b0;
            OUT_CIRCUIT_2_O <= 1'b0;
            OUT_CIRCUIT_3_O <= 1'b0;
        end
        else
        begin
            OUT_CIRCUIT_1_O <= fin_out[0];
            OUT_CIRCUIT_2_O <= fin_out[1];
            OUT_CIRCUIT_3_O <= fin_out[2];
        end
    end

    // one flop from the inputs, far inside the allowed delay
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
            SAFETY_MONITOR_OUT_O <= 1'b0;
        else
            SAFETY_MONITOR_OUT_O <= edm_nxt;
    end

    // both halves of a pair come from flops of one edge, so a pair never skews
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
        begin
            QUAD_PHASE_A_O   <= 1'b0;
            QUAD_PHASE_A_N_O <= 1'b1;
            QUAD_PHASE_B_O   <= 1'b0;
            QUAD_PHASE_B_N_O <= 1'b1;
            ORIGIN_PULSE_O   <= 1'b0;
            ORIGIN_PULSE_N_O <= 1'b1;
        end
        else
        begin
            QUAD_PHASE_A_O   <= qa;
            QUAD_PHASE_A_N_O <= !qa;
            QUAD_PHASE_B_O   <= qb;
            QUAD_PHASE_B_N_O <= !qb;
            ORIGIN_PULSE_O   <= qc;
            ORIGIN_PULSE_N_O <= !qc;
        end
    end

endmodule : osr_top

// ==== verif/osr_host_model.sv ====
// host line receiver: turns the quadrature pairs back into a signed position count
// assumes the pairs are sampled on the router clock
`timescale 1ns/1ps

module osr_host_model
(
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          a_i,
    input  wire logic          a_n_i,
    input  wire logic          b_i,
    input  wire logic          b_n_i,
    input  wire logic          c_i,
    input  wire logic          c_n_i,
    output logic signed [31:0] pos_o,
    output logic               bad_o
);
    logic [1:0] idx;
    logic [1:0] prev_r;
    logic       pair_bad;
    // step index of the 00,01,11,10 sequence
    assign idx = {a_i, a_i ^ b_i};
    assign pair_bad = (a_i == a_n_i) || (b_i == b_n_i) || (c_i == c_n_i);

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            prev_r <= 2'h0;
            pos_o <= 32'sh0;
            bad_o <= 1'b0;
        end
        else
        begin
            prev_r <= idx;
            bad_o <= bad_o | pair_bad;
            if (idx == prev_r + 2'h1)
                pos_o <= pos_o + 32'sh1;
            else if (idx == prev_r - 2'h1)
                pos_o <= pos_o - 32'sh1;
        end
    end
endmodule : osr_host_model

// ==== verif/osr_top_sva.sv ====
// port checker of the output signal router: apb answer, safety monitor, pulse pairs
// assumes one clock domain and binding onto every osr_top instance
`timescale 1ns/1ps

module osr_top_sva
(
    input wire logic        CORE_CLK_I,
    input wire logic        RST_N_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic        SAFE_BLOCK_IN_1_N_I,
    input wire logic        SAFE_BLOCK_IN_2_N_I,
    input wire logic        SAFETY_MONITOR_OUT_O,
    input wire logic        QUAD_PHASE_A_O,
    input wire logic        QUAD_PHASE_A_N_O,
    input wire logic        QUAD_PHASE_B_O,
    input wire logic        QUAD_PHASE_B_N_O,
    input wire logic        ORIGIN_PULSE_O,
    input wire logic        ORIGIN_PULSE_N_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);

    sequence seq_setup;
        PSEL_I && !PENABLE_I;
    endsequence
    sequence seq_wait;
        PSEL_I && PENABLE_I && !PREADY_O;
    endsequence

    AST_ONE_WAIT: assert property (seq_setup ##1 seq_wait |=> PREADY_O)
        else $error("ready missing in second access cycle");
    AST_READY_PULSE: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    AST_ERR_WITH_READY: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    AST_IDLE_DATA: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
        else $error("read data outside answer cycle");
    AST_MONITOR: assert property ($past(RST_N_I, 2) |-> SAFETY_MONITOR_OUT_O ==
        $past(!SAFE_BLOCK_IN_1_N_I && !SAFE_BLOCK_IN_2_N_I))
        else $error("safety monitor does not follow both inputs");
    AST_QUAD_PAIRS: assert property (QUAD_PHASE_A_N_O != QUAD_PHASE_A_O && QUAD_PHASE_B_N_O != QUAD_PHASE_B_O)
        else $error("quadrature pair not complementary");
    AST_ORIGIN_PAIR: assert property (ORIGIN_PULSE_N_O != ORIGIN_PULSE_O)
        else $error("origin pair not complementary");
    AST_GRAY_STEP: assert property ($past(RST_N_I) |->
        $onehot0({QUAD_PHASE_A_O, QUAD_PHASE_B_O} ^ $past({QUAD_PHASE_A_O, QUAD_PHASE_B_O})))
        else $error("both phases changed at once");
endmodule : osr_top_sva

bind osr_top osr_top_sva osr_top_sva_inst (.*);

// ==== verif/output_signal_router_tb.sv ====
// self-checking bench of the output signal router over apb
// assumes osr_params.svh on the include path; the host model decodes the pulses
`timescale 1ns/1ps
`include "osr_params.svh"

module output_signal_router_tb;
    logic clk, rst_n, psel, pen, pwr, pready, pslverr, vld, mon, qa, qan, qb, qbn, oc, ocn, bad;
    logic [31:0] paddr, pwdata, prdata, pos;
    logic signed [31:0] hp;
    logic [1:0] mode, sn;
    logic [8:0] st;
    logic [2:0] o;
    int errors = 0;
    int n_tests = 0;

    osr_top #(.QDIV(4)) osr_top_inst (.CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .CTRL_MODE_I(mode), .POSITION_DONE_I(st[0]), .SPEED_MATCH_I(st[1]),
        .MOVING_I(st[2]), .SERVO_READY_I(st[3]), .FORCE_LIMITED_I(st[4]), .SPEED_LIMITED_I(st[5]),
        .HOLDING_BRAKE_I(st[6]), .WARNING_I(st[7]), .NEAR_I(st[8]), .SAFE_BLOCK_IN_1_N_I(sn[1]),
        .SAFE_BLOCK_IN_2_N_I(sn[0]), .SCALE_POS_I(pos), .SCALE_POS_VLD_I(vld), .OUT_CIRCUIT_1_O(o[0]),
        .OUT_CIRCUIT_2_O(o[1]), .OUT_CIRCUIT_3_O(o[2]), .SAFETY_MONITOR_OUT_O(mon), .QUAD_PHASE_A_O(qa),
        .QUAD_PHASE_A_N_O(qan), .QUAD_PHASE_B_O(qb), .QUAD_PHASE_B_N_O(qbn), .ORIGIN_PULSE_O(oc),
        .ORIGIN_PULSE_N_O(ocn));
    osr_host_model osr_host_model_inst (.clk_i(clk), .rst_n_i(rst_n), .a_i(qa), .a_n_i(qan), .b_i(qb),
        .b_n_i(qbn), .c_i(oc), .c_n_i(ocn), .pos_o(hp), .bad_o(bad));

    task conclude;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task apb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd,
             output logic er);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task settle;
        repeat (3) @(posedge clk);
        #1;
    endtask : settle

    task move(input logic [31:0] p);
        @(posedge clk);
        pos <= p;
        vld <= 1'b1;
        @(posedge clk);
        vld <= 1'b0;
        repeat (40) @(posedge clk);
        #1;
    endtask : move

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        conclude();
    end

    initial
    begin
        logic [31:0] rd;
        logic er;
        logic [31:0] rstv [5];
        logic [31:0] mexp [4];
        rstv = '{32'(`OSR_RST_SEL_A), 32'(`OSR_RST_SEL_B), 32'(`OSR_RST_SEL_NEAR), 32'(`OSR_RST_POL_INV),
                 32'(`OSR_RST_ORIGIN)};
        mexp = '{32'h4, 32'h1, 32'h2, 32'h0};
        {rst_n, psel, pen, pwr, vld, mode, st} = '0;
        {paddr, pwdata, pos} = '0;
        sn = 2'h3;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, 32'(4 * i), 32'h0, rd, er);
            check(rd, rstv[i]);
        end
        apb(1'b0, 32'h18, 32'h0, rd, er);
        check({er, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, `OSR_OFF_STATUS, 32'hFFFF, rd, er);
        check({31'h0, er}, 32'h1);
        st <= 9'h004;
        for (int c = 0; c < 6; c++)
        begin
            apb(1'b1, `OSR_OFF_SEL_A, 32'(c) << 8, rd, er);
            settle();
            check({29'h0, o}, (c >= 1 && c <= 3) ? 32'h1 << (c - 1) : 32'h0);
        end
        apb(1'b1, `OSR_OFF_SEL_A, 32'h2200, rd, er);
        for (int s = 0; s < 4; s++)
        begin
            st <= 9'(s) << 2;
            settle();
            check({29'h0, o}, (s != 0) ? 32'h2 : 32'h0);
        end
        apb(1'b1, `OSR_OFF_SEL_A, 32'h0003, rd, er);
        st <= 9'h001;
        for (int m = 0; m < 3; m++)
        begin
            mode <= 2'(m);
            settle();
            check({29'h0, o}, (m == 0) ? 32'h4 : 32'h0);
        end
        st <= 9'h040;
        for (int p = 0; p < 8; p++)
        begin
            apb(1'b1, `OSR_OFF_POL_INV, 32'(p), rd, er);
            settle();
            check({29'h0, o}, 32'(p) ^ 32'h1);
        end
        for (int k = 0; k < 4; k++)
        begin
            sn <= 2'(k);
            settle();
            check({31'h0, mon}, (k == 0) ? 32'h1 : 32'h0);
        end
        apb(1'b0, `OSR_OFF_STATUS, 32'h0, rd, er);
        check(rd, 32'h0000_034C);
        apb(1'b1, `OSR_OFF_POL_INV, 32'h0, rd, er);
        apb(1'b1, `OSR_OFF_SEL_A, 32'h0010, rd, er);
        apb(1'b1, `OSR_OFF_SEL_B, 32'h0020, rd, er);
        apb(1'b1, `OSR_OFF_SEL_NEAR, 32'h0003, rd, er);
        st <= 9'h122;
        for (int m = 0; m < 4; m++)
        begin
            mode <= 2'(m);
            settle();
            check({29'h0, o}, mexp[m]);
        end
        apb(1'b1, `OSR_OFF_ORIGIN, 32'h3, rd, er);
        apb(1'b0, `OSR_OFF_ORIGIN, 32'h0, rd, er);
        check(rd, 32'h3);
        move(32'h5);
        check(hp, 32'h5);
        check({31'h0, oc}, 32'h0);
        move(32'h3);
        check(hp, 32'h3);
        check({31'h0, oc}, 32'h1);
        check({31'h0, bad}, 32'h0);
        conclude();
    end
endmodule : output_signal_router_tb
